// >>> src/hpp_cfg.svh
// Constants for the parallel host port: widths, field positions, reset values, counts
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH

`define HPP_DATA_W        13       // Full data bus width
`define HPP_NARROW_W      8        // Active lines in narrow mode
`define HPP_HI_W          5        // Upper lines, carried in the second narrow transfer
`define HPP_SYNC_STAGES   3        // Flip-flops on every pin input
`define HPP_CHAN_MSB      3        // Channel select field, top bit
`define HPP_SYNC_DIR_BIT  8        // Sync pin direction bit
`define HPP_BW_BIT        12       // Bus width bit
`define HPP_CFG_RESET     13'h0000 // Configuration word after reset
`define HPP_STRAP_WAIT    3'h5     // Cycles after release before the strap is read
`define HPP_PINS_IDLE     3'h7     // Select and strobes idle high

`endif

// >>> src/hpp_pkg.sv
// Types shared by the parallel host port
package hpp_pkg;

  // Host strobes, all active low
  typedef struct packed {
    logic cs_n;  // Chip select
    logic rd_n;  // Read strobe
    logic wr_n;  // Write strobe
  } host_pins_s;

  // Configuration word layout, bit 12 down to bit 0
  typedef struct packed {
    logic       bus_wide;      // Bus width select, bit 12
    logic [2:0] rsv_hi;        // Bits 11..9, stored only
    logic       sync_is_input; // Sync pin direction, bit 8
    logic [3:0] rsv_mid;       // Bits 7..4, stored only
    logic [3:0] chan_sel;      // Channel select, bits 3..0
  } cfg_s;

  // Which half of a word the next narrow transfer carries
  typedef enum logic {
    BYTE_LO = 1'b0,  // Lines 7..0 of the word
    BYTE_HI = 1'b1   // Lines 12..8 of the word
  } byte_e;

endpackage

// >>> src/sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "hpp_cfg.svh"

module sync3 #(
  parameter int           W   = 1,   // Bits carried
  parameter logic [W-1:0] RST = '0   // Value held during reset
) (
  input  wire logic         clk,    // System clock
  input  wire logic         reset,  // Synchronous reset, active high
  input  wire logic [W-1:0] d,      // Asynchronous pin level
  output logic      [W-1:0] q       // Filtered level
);

  logic [W-1:0] s1;  // First stage, read only by s2
  logic [W-1:0] s2;  // Second stage
  logic [W-1:0] s3;  // Third stage

  // Shift chain; output moves only when stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= RST;
      s2 <= RST;
      s3 <= RST;
      q  <= RST;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end

endmodule
`default_nettype wire

// >>> src/adc_parallel_host_port.sv
// Parallel host port of a sampling converter: strobes, data lines, sync, ready, standby
//
// Notes on behaviour
// - Strap low: latch data on write rise
// - Strap high: latch data on write fall
// - Config bit 8 sets sync pin direction
// - Sync input rising edge starts a conversion
// - Sync output high during each conversion; a begin in the same cycle as a done leaves it low
// - Bit 12 picks eight or thirteen lines
// - Line 12 is msb, line 0 lsb
// - Input buffers on while write and select low
// - Drive lines only while read and select low
// - Active-low ready marks function begun or ended
// - Standby output low only while in standby
// - Bits 3..0 route channels to selector
`timescale 1ns/1ps
`default_nettype none
`include "hpp_cfg.svh"

module adc_parallel_host_port
  import hpp_pkg::*;
(
  input  wire logic                   clk,                 // System clock, 125 MHz
  input  wire logic                   reset,               // Synchronous reset, active high
  input  wire host_pins_s             host_pins,           // Select and strobes from the pins
  input  wire logic [`HPP_DATA_W-1:0] host_data_lines_in,  // Data lines as seen at the pins
  output logic      [`HPP_DATA_W-1:0] host_data_lines_out, // Data lines driven value
  output logic      [`HPP_DATA_W-1:0] host_data_lines_oe,  // Per-line drive enable
  output logic                        in_buf_en,           // Data input buffers enabled
  input  wire logic                   latch_edge_strap,    // Write edge strap pin
  input  wire logic                   sync_in,             // Sync pin level
  output logic                        sync_out,            // Sync pin driven value
  output logic                        sync_oe,             // Sync pin drive enable
  output logic                        rdy_n,               // Ready, active low
  output logic                        sleep_state_n,       // Low while in standby with no wake request
  input  wire logic                   conv_begin,          // Core started a conversion
  input  wire logic                   conv_done,           // Core finished a conversion
  input  wire logic [`HPP_DATA_W-1:0] conv_result,         // Result, valid with conv_done
  input  wire logic                   core_standby,        // Core is in standby
  input  wire logic                   wake_req,            // Leave standby has been asked
  output logic                        conv_trigger,        // Start pulse to the core
  output logic [`HPP_CHAN_MSB:0]      chan_route,          // Channel select to the selector
  output logic                        bus_width_sel        // Current bus width, 1 = wide
);

  host_pins_s             pins_q;      // Filtered strobes
  logic [`HPP_DATA_W-1:0] data_q;      // Filtered data lines
  logic                   strap_q;     // Filtered strap
  logic                   sync_q;      // Filtered sync pin
  host_pins_s             pins_prev_r; // Strobes one cycle ago
  logic                   sync_prev_r; // Sync level one cycle ago
  logic [2:0]             strap_cnt_r; // Wait before reading strap
  logic                   strap_done_r;// Strap has been taken
  logic                   edge_fall_r; // 1 = latch on falling write edge
  cfg_s                   cfg_r;       // Configuration word
  byte_e                  wr_phase_r;  // Next narrow write half
  byte_e                  rd_phase_r;  // Next narrow read half
  logic [`HPP_DATA_W-1:0] result_r;    // Last conversion result
  logic                   wr_act;      // Write and select low
  logic                   rd_act;      // Read and select low
  logic                   wr_take;     // Write edge that latches data
  logic                   rd_end;      // Read strobe released while selected
  logic                   start_any;   // A conversion begins this cycle

  // Pin synchronisers, idle strobes reset high
  sync3 #(.W(3), .RST(`HPP_PINS_IDLE)) u_sync_pins (
    .clk   (clk),
    .reset (reset),
    .d     (host_pins),
    .q     (pins_q)
  );
  sync3 #(.W(`HPP_DATA_W), .RST(`HPP_CFG_RESET)) u_sync_data (
    .clk   (clk),
    .reset (reset),
    .d     (host_data_lines_in),
    .q     (data_q)
  );
  sync3 #(.W(2), .RST(2'h0)) u_sync_misc (
    .clk   (clk),
    .reset (reset),
    .d     ({latch_edge_strap, sync_in}),
    .q     ({strap_q, sync_q})
  );

  // Strobe decode and edge events
  always_comb begin
    wr_act    = !pins_q.wr_n && !pins_q.cs_n;
    rd_act    = !pins_q.rd_n && !pins_q.cs_n;
    // Fall: strobe goes low under select; rise: strobe leaves low while selected
    wr_take   = edge_fall_r ? (wr_act && !(!pins_prev_r.wr_n && !pins_prev_r.cs_n))
                            : (!pins_prev_r.wr_n && !pins_prev_r.cs_n
                               && pins_q.wr_n && !pins_q.cs_n);
    rd_end    = !pins_prev_r.rd_n && !pins_prev_r.cs_n && pins_q.rd_n;
    start_any = conv_begin || conv_trigger;
  end

  // Previous levels for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      pins_prev_r <= `HPP_PINS_IDLE;
      sync_prev_r <= 1'b0;
    end else begin
      pins_prev_r <= pins_q;
      sync_prev_r <= sync_q;
    end
  end

  // Strap read once, after the synchroniser has settled
  // Filtered level moves only on the fourth edge after release, so wait past it
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_cnt_r  <= 3'h0;
      strap_done_r <= 1'b0;
      edge_fall_r  <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == `HPP_STRAP_WAIT) begin
        edge_fall_r  <= strap_q;
        strap_done_r <= 1'b1;
      end else begin
        strap_cnt_r <= strap_cnt_r + 3'h1;
      end
    end
  end

  // Configuration writes; narrow mode takes low half then high half
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r      <= `HPP_CFG_RESET;
      wr_phase_r <= BYTE_LO;
    end else if (wr_take && strap_done_r) begin
      if (cfg_r.bus_wide) begin
        cfg_r      <= data_q;
        wr_phase_r <= BYTE_LO;
      end else if (wr_phase_r == BYTE_LO) begin
        cfg_r[`HPP_NARROW_W-1:0] <= data_q[`HPP_NARROW_W-1:0];
        wr_phase_r               <= BYTE_HI;
      end else begin
        cfg_r[`HPP_DATA_W-1:`HPP_NARROW_W] <= data_q[`HPP_HI_W-1:0];
        wr_phase_r                         <= BYTE_LO;
      end
    end
  end

  // Configuration fields and input buffer enable out to the rest of the converter
  always_ff @(posedge clk) begin
    if (reset) begin
      chan_route    <= 4'h0;
      bus_width_sel <= 1'b0;
      in_buf_en     <= 1'b0;
    end else begin
      chan_route    <= cfg_r.chan_sel;
      bus_width_sel <= cfg_r.bus_wide;
      in_buf_en     <= wr_act;
    end
  end

  // Result capture and read half tracking
  always_ff @(posedge clk) begin
    if (reset) begin
      result_r   <= `HPP_CFG_RESET;
      rd_phase_r <= BYTE_LO;
    end else begin
      if (conv_done) begin
        result_r <= conv_result;
      end
      if (rd_end && !cfg_r.bus_wide) begin
        rd_phase_r <= (rd_phase_r == BYTE_LO) ? BYTE_HI : BYTE_LO;
      end else if (cfg_r.bus_wide) begin
        rd_phase_r <= BYTE_LO;
      end
    end
  end

  // Data line drive: only under read and select, narrow mode keeps top lines off
  always_ff @(posedge clk) begin
    if (reset) begin
      host_data_lines_out <= `HPP_CFG_RESET;
      host_data_lines_oe  <= `HPP_CFG_RESET;
    end else if (!rd_act) begin
      host_data_lines_oe  <= `HPP_CFG_RESET;
    end else if (cfg_r.bus_wide) begin
      host_data_lines_out <= result_r;
      host_data_lines_oe  <= {`HPP_DATA_W{1'b1}};
    end else begin
      host_data_lines_oe  <= {{`HPP_HI_W{1'b0}}, {`HPP_NARROW_W{1'b1}}};
      if (rd_phase_r == BYTE_LO) begin
        host_data_lines_out <= {{`HPP_HI_W{1'b0}}, result_r[`HPP_NARROW_W-1:0]};
      end else begin
        host_data_lines_out <= {{`HPP_NARROW_W{1'b0}}, result_r[`HPP_DATA_W-1:`HPP_NARROW_W]};
      end
    end
  end

  // Sync pin: trigger on rising input, or mark the conversion as output
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_oe      <= 1'b1;
      sync_out     <= 1'b0;
      conv_trigger <= 1'b0;
    end else begin
      sync_oe      <= !cfg_r.sync_is_input;
      conv_trigger <= cfg_r.sync_is_input && sync_q && !sync_prev_r;
      if (cfg_r.sync_is_input) begin
        sync_out <= 1'b0;
      end else if (conv_done) begin
        sync_out <= 1'b0;
      end else if (conv_begin) begin
        sync_out <= 1'b1;
      end
    end
  end

  // Ready: high from a start until done, but done wins when it lands in the start cycle; low once done until the result is read
  always_ff @(posedge clk) begin
    if (reset) begin
      rdy_n <= 1'b1;
    end else if (conv_done) begin
      rdy_n <= 1'b0;
    end else if (start_any) begin
      rdy_n <= 1'b1;
    end else if (rd_end && (cfg_r.bus_wide || rd_phase_r == BYTE_HI)) begin
      rdy_n <= 1'b1;
    end
  end

  // Standby status
  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_state_n <= 1'b1;
    end else begin
      sleep_state_n <= !(core_standby && !wake_req);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_sync_rise;
    !sync_prev_r ##0 sync_q ##0 cfg_r.sync_is_input;
  endsequence
  sequence s_write_rise;
    (!pins_q.wr_n && !pins_q.cs_n) ##1 (pins_q.wr_n && !pins_q.cs_n);
  endsequence

  chk_sync_dir_oe: assert property (##1 sync_oe == !$past(cfg_r.sync_is_input))
    else $error("sync drive does not follow direction bit");
  chk_sync_trig: assert property (s_sync_rise |=> conv_trigger)
    else $error("sync rising edge gave no trigger");
  chk_trig_cause: assert property (conv_trigger |-> $past(cfg_r.sync_is_input))
    else $error("trigger while sync is an output");
  chk_sync_out_hi: assert property (conv_begin && !conv_done && !cfg_r.sync_is_input
                                    |=> sync_out [*1] ##0 sync_oe)
    else $error("sync output not high at conversion start");
  chk_sync_out_lo: assert property (conv_done |=> !sync_out)
    else $error("sync output not low after conversion");
  chk_narrow_float: assert property (!bus_width_sel && !cfg_r.bus_wide
                                     |=> host_data_lines_oe[`HPP_DATA_W-1:`HPP_NARROW_W] == 5'h00)
    else $error("upper lines driven in narrow mode");
  chk_read_drive: assert property (|host_data_lines_oe |-> $past(rd_act))
    else $error("data lines driven without read and select");
  chk_in_buf: assert property (##1 in_buf_en == $past(wr_act))
    else $error("input buffer enable wrong");
  chk_wide_order: assert property (rd_act && cfg_r.bus_wide |=> host_data_lines_out == $past(result_r))
    else $error("wide read lines out of order");
  chk_rise_latch: assert property (strap_done_r && !edge_fall_r && cfg_r.bus_wide
                                   ##0 s_write_rise |=> cfg_r == $past(data_q))
    else $error("rising write edge did not latch");
  chk_ready_done: assert property (conv_done |=> !rdy_n)
    else $error("ready not low after conversion");
  chk_standby: assert property (core_standby && !wake_req |=> !sleep_state_n)
    else $error("standby output not low in standby");
  chk_chan_route: assert property (##1 chan_route == $past(cfg_r.chan_sel))
    else $error("channel route does not follow field");

endmodule
`default_nettype wire

// >>> sim/host_bus_model.sv
// Host bus model: drives select, strobes and data lines of the port
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
  import hpp_pkg::*;
(
  input  wire logic        clk,     // System clock
  input  wire logic [12:0] dev_out, // Value the port drives
  input  wire logic [12:0] dev_oe,  // Port drive enables
  output var  host_pins_s  pins,    // Select and strobes, active low
  output logic      [12:0] lines    // Resolved data line levels
);
  logic        drv_r;  // Host drives the lines
  logic [12:0] dat_r;  // Value the host drives
  logic [12:0] last_r; // Last value the host drove

  // Idle bus at time zero
  initial begin
    pins   = 3'h7;
    drv_r  = 1'b0;
    dat_r  = 13'h0000;
    last_r = 13'h0000;
  end

  // Released lines show the inverse of the last host value, never a stale copy
  assign lines = (dev_oe & dev_out) | (~dev_oe & (drv_r ? dat_r : ~last_r));

  // Change the bus just after an edge, then hold it for n cycles
  task automatic step(input logic cs_n, rd_n, wr_n, drv, input logic [12:0] d,
                      input int n);
    @(posedge clk);
    pins  <= '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n};
    drv_r <= drv;
    dat_r <= d;
    if (drv) begin
      last_r <= d;
    end
    repeat (n - 1) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the parallel host port
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import hpp_pkg::*;
  logic        clk, reset, strap, sync_in;     // Clock, reset, strap, sync pin
  logic        conv_begin, conv_done;          // Core conversion events
  logic        core_standby, wake_req;         // Core standby state
  logic [12:0] result, lines, d_out, d_oe;     // Result and data lines
  logic [12:0] oe, dat;                        // Values taken by a read
  logic        in_buf_en, sync_out, sync_oe;   // Buffer and sync outputs
  logic        rdy_n, sleep_state_n, trig, bw; // Status outputs
  logic [3:0]  chan;                           // Channel route
  host_pins_s  pins;                           // Host strobes
  int          failures, comparisons, n;       // Counters
  // Rows: core_standby, wake_req, expected standby output
  logic [2:0]  rows [4] = '{3'b001, 3'b011, 3'b100, 3'b111};

  host_bus_model host (.clk(clk), .dev_out(d_out), .dev_oe(d_oe), .pins(pins),
                       .lines(lines));

  adc_parallel_host_port dut (
    .clk(clk), .reset(reset), .host_pins(pins), .host_data_lines_in(lines),
    .host_data_lines_out(d_out), .host_data_lines_oe(d_oe), .in_buf_en(in_buf_en),
    .latch_edge_strap(strap), .sync_in(sync_in), .sync_out(sync_out),
    .sync_oe(sync_oe), .rdy_n(rdy_n), .sleep_state_n(sleep_state_n),
    .conv_begin(conv_begin), .conv_done(conv_done), .conv_result(result),
    .core_standby(core_standby), .wake_req(wake_req), .conv_trigger(trig),
    .chan_route(chan), .bus_width_sel(bw));

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare and report
  task automatic chk(input string name, input logic [12:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask

  // Counts, verdict, end of run
  task automatic close_out;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Wait k edges, then let updates settle
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Reset for 10 cycles; strap stays fixed from release on
  task automatic do_reset(input logic s);
    @(posedge clk);
    reset <= 1'b1;
    strap <= s;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    cyc(10);
  endtask

  // One write; optionally checks the channel while the strobe is still low
  task automatic wr(input logic [12:0] d, input logic mid, input logic [3:0] e);
    host.step(1'b0, 1'b1, 1'b0, 1'b1, d, 10);
    #1;
    chk("in_buf_en", 13'h0001, in_buf_en);
    if (mid) begin
      chk("chan_route mid", e, chan);
    end
    host.step(1'b0, 1'b1, 1'b1, 1'b1, d, 10);
    host.step(1'b1, 1'b1, 1'b1, 1'b0, 13'h0000, 10);
  endtask

  // One read, held until the port drives, bounded
  task automatic rd(output logic [12:0] o, q);
    host.step(1'b0, 1'b0, 1'b1, 1'b0, 13'h0000, 1);
    cyc(1);
    for (n = 0; n < 20 && d_oe === 13'h0000; n++) cyc(1);
    if (n == 20) begin
      failures++;
      close_out;
    end
    o = d_oe;
    q = d_out;
    host.step(1'b1, 1'b1, 1'b1, 1'b0, 13'h0000, 8);
    #1;
  endtask

  // One-cycle core event pulse
  task automatic pulse(input logic b, d);
    @(posedge clk);
    conv_begin <= b;
    conv_done  <= d;
    @(posedge clk);
    conv_begin <= 1'b0;
    conv_done  <= 1'b0;
    #1;
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    strap = 1'b0;
    sync_in = 1'b0;
    conv_begin = 1'b0;
    conv_done = 1'b0;
    core_standby = 1'b0;
    wake_req = 1'b0;
    result = 13'h1A5C;
    failures = 0;
    comparisons = 0;
    do_reset(1'b0);
    chk("oe", 13'h0000, d_oe);
    chk("sync_oe", 13'h0001, sync_oe);
    chk("rdy_n", 13'h0001, rdy_n);
    // Standby table
    foreach (rows[i]) begin
      @(posedge clk);
      core_standby <= rows[i][2];
      wake_req     <= rows[i][1];
      cyc(2);
      chk("sleep_state_n", rows[i][0], sleep_state_n);
    end
    // Write with select high is ignored
    host.step(1'b1, 1'b1, 1'b0, 1'b1, 13'h1FFF, 10);
    #1;
    chk("in_buf_en", 13'h0000, in_buf_en);
    host.step(1'b1, 1'b1, 1'b1, 1'b0, 13'h0000, 10);
    #1;
    chk("chan_route", 13'h0000, chan);
    // Narrow pair: wide bus, sync input, channel 5
    wr(13'h0005, 1'b0, 4'h0);
    wr(13'h0011, 1'b0, 4'h0);
    cyc(2);
    chk("chan_route", 13'h0005, chan);
    chk("bus_width_sel", 13'h0001, bw);
    chk("sync_oe", 13'h0000, sync_oe);
    wr(13'h1103, 1'b1, 4'h5);
    cyc(2);
    chk("chan_route", 13'h0003, chan);
    // Sync input rise starts a conversion
    @(posedge clk);
    sync_in <= 1'b1;
    for (n = 0; n < 12 && trig !== 1'b1; n++) cyc(1);
    if (n == 12) begin
      failures++;
      close_out;
    end
    chk("conv_trigger", 13'h0001, trig);
    cyc(1);
    chk("conv_trigger", 13'h0000, trig);
    @(posedge clk);
    sync_in <= 1'b0;
    pulse(1'b0, 1'b1);
    chk("rdy_n", 13'h0000, rdy_n);
    rd(oe, dat);
    chk("oe", 13'h1FFF, oe);
    chk("data", 13'h1A5C, dat);
    chk("oe idle", 13'h0000, d_oe);
    chk("rdy_n", 13'h0001, rdy_n);
    // Narrow bus, sync output
    wr(13'h0000, 1'b0, 4'h0);
    cyc(2);
    chk("sync_oe", 13'h0001, sync_oe);
    pulse(1'b1, 1'b0);
    chk("sync_out", 13'h0001, sync_out);
    pulse(1'b0, 1'b1);
    chk("sync_out", 13'h0000, sync_out);
    rd(oe, dat);
    chk("oe lo", 13'h00FF, oe);
    chk("data lo", 13'h005C, {5'h00, dat[7:0]});
    chk("rdy_n after lo", 13'h0000, rdy_n);
    rd(oe, dat);
    chk("oe hi", 13'h0000, {oe[12:8], 8'h00});
    chk("data hi", 13'h001A, {8'h00, dat[4:0]});
    chk("rdy_n after hi", 13'h0001, rdy_n);
    // Strap high: data taken on write fall
    do_reset(1'b1);
    wr(13'h0007, 1'b0, 4'h0);
    wr(13'h0010, 1'b0, 4'h0);
    wr(13'h1102, 1'b1, 4'h2);
    close_out;
  end
endmodule

`default_nettype wire
